// ---- stt_pkg.sv ----
// package: register map, field positions and reset values of the system tick timer
package stt_pkg;
  localparam int unsigned CNT_W          = 24;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned SYNC_W         = 2;
  localparam logic [31:0] ADDR_CSR       = 32'he000_e010;
  localparam logic [31:0] ADDR_RVR       = 32'he000_e014;
  localparam logic [31:0] ADDR_CVR       = 32'he000_e018;
  localparam logic [31:0] ADDR_CAL       = 32'he000_e01c;
  localparam logic [31:0] ADDR_IST       = 32'he000_e020;
  localparam logic [31:0] ADDR_IMSK      = 32'he000_e024;
  localparam logic [1:0]  ALIGN_OK       = 2'h0;
  localparam int unsigned CSR_EN_BIT     = 0;
  localparam int unsigned CSR_INT_BIT    = 1;
  localparam int unsigned CSR_SRC_BIT    = 2;
  localparam int unsigned CSR_FLAG_BIT   = 16;
  localparam int unsigned CAL_NO_REFERENCE_CLOCK_BIT  = 31;
  localparam int unsigned CAL_SKEW_BIT   = 30;
  localparam int unsigned IST_ZERO_BIT   = 0;
  localparam logic [31:0] CSR_RST        = 32'h0000_0000;
  localparam logic [23:0] CAL_TEN_MILLISECOND_RELOAD_RST  = 24'h00_1770;
  localparam logic [23:0] CNT_ZERO       = 24'h00_0000;
  localparam logic [23:0] CNT_ONE        = 24'h00_0001;
  localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
endpackage

// ---- stt_cnt_if.sv ----
// interface: control and status between register block and down counter
`timescale 1ns/1ps
interface stt_cnt_if;
  logic                         tick;
  logic                         load;
  logic                         clear;
  logic [stt_pkg::CNT_W-1:0]    reload_val;
  logic [stt_pkg::CNT_W-1:0]    cur;
  logic                         zero_evt;
  modport ctl (output tick, output load, output clear, output reload_val, input cur, input zero_evt);
  modport cnt (input tick, input load, input clear, input reload_val, output cur, output zero_evt);
endinterface

// ---- stt_sync.sv ----
// module: two-flop synchronisers for pin inputs
`timescale 1ns/1ps
module stt_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } stt_sync_state_type;

  stt_sync_state_type st_ff;
  stt_sync_state_type nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = async_i;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.sync;
endmodule // stt_sync

// ---- stt_counter.sv ----
// module: 24-bit down counter with reload and zero-reached pulse
`timescale 1ns/1ps
module stt_counter (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  stt_cnt_if.cnt    cif
);
  typedef struct packed {
    logic [stt_pkg::CNT_W-1:0] cur;
    logic                      zero_evt;
  } stt_cnt_state_type;

  stt_cnt_state_type st_ff;
  stt_cnt_state_type nxt_st;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.zero_evt = 1'b0;
    if (cif.clear) begin
      nxt_st.cur = stt_pkg::CNT_ZERO; // R13
    end else if (cif.load) begin
      nxt_st.cur = cif.reload_val; // R10
    end else if (cif.tick) begin
      if (st_ff.cur == stt_pkg::CNT_ZERO) begin
        nxt_st.cur = cif.reload_val; // R1
      end else begin
        nxt_st.cur      = st_ff.cur - stt_pkg::CNT_ONE; // R1
        nxt_st.zero_evt = (st_ff.cur == stt_pkg::CNT_ONE); // R11
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.cur      = st_ff.cur;
  assign cif.zero_evt = st_ff.zero_evt;
endmodule // stt_counter

// ---- stt_timer.sv ----
// module: system tick timer top with apb registers, interrupt and exception request
//
// What this block does
// R1: 24-bit counter decrements per counting clock, reloads on edge after zero.
// R2: debugger halt freezes the counter value.
// R3: counter runs only on processor clock edges; stopped clock stops counting.
// R4: software uses aligned 32-bit word accesses only.
// R5: software writes reload, clears current, then programs control/status.
// R6: control/status resets to zero; calibration reads its fixed default word.
// R7: count flag reads 1 if zero was reached since its last read.
// R8: clock-source bit 0 selects reference clock, 1 selects processor clock.
// R9: exception enable set makes reaching zero raise the tick exception request.
// R10: enable loads reload value and counts; zero sets flag, requests, reloads.
// R11: reload range 1 to max; reload zero never gives flag or request.
// R12: software programs N-1 for a period of N counting clocks.
// R13: writing current value clears counter and count flag; reads give live value.
// R14: with no reference clock, clock-source bit reads one and ignores writes.
// R15: calibration ten-millisecond field holds 10 ms reload; zero means unknown.
// R16: reading control/status returns count flag and clears it.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module stt_timer #(
  parameter logic                      NO_REF = 1'h0,
  parameter logic                      SKEW   = 1'h0,
  parameter logic [stt_pkg::CNT_W-1:0] TEN_MILLISECOND_RELOAD  = stt_pkg::CAL_TEN_MILLISECOND_RELOAD_RST
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [31:0]                paddr_i,
  input  wire logic [stt_pkg::DATA_W-1:0] pwdata_i,
  output logic      [stt_pkg::DATA_W-1:0] prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       ref_clk_i,
  input  wire logic                       dbg_halt_i,
  output logic                            tick_exc_o,
  output logic                            irq_o
);
  typedef struct packed {
    logic                       en;
    logic                       tick_exception_enable;
    logic                       clksrc;
    logic [stt_pkg::CNT_W-1:0]  reload;
    logic                       flag;
    logic                       ist;
    logic                       imsk;
    logic [stt_pkg::DATA_W-1:0] prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       exc;
    logic                       irq;
    logic                       ref_prev;
  } stt_state_type;

  stt_state_type st_ff;
  stt_state_type nxt_st;

  stt_cnt_if cif ();

  logic [stt_pkg::SYNC_W-1:0] sync_s;
  logic                       ref_s;
  logic                       halt_s;
  logic                       ref_rise;
  logic                       src_eff;
  logic                       prep;
  logic                       done;
  logic                       hit_csr;
  logic                       hit_rvr;
  logic                       hit_cvr;
  logic                       hit_cal;
  logic                       hit_ist;
  logic                       hit_imsk;
  logic                       bad;
  logic                       wr_ok;
  logic                       wr_csr;
  logic                       wr_rvr;
  logic                       wr_cvr;
  logic                       wr_imsk;
  logic                       rd_csr;
  logic                       rd_ist;
  logic [stt_pkg::DATA_W-1:0] csr_val;
  logic [stt_pkg::DATA_W-1:0] cal_val;
  logic [stt_pkg::DATA_W-1:0] rd_mux;

  // pin inputs: reference clock and debug halt
  stt_sync #(
    .W (stt_pkg::SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({dbg_halt_i, ref_clk_i}),
    .sync_o    (sync_s)
  );

  assign ref_s  = sync_s[0];
  assign halt_s = sync_s[1];

  stt_counter u_counter (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .cif       (cif)
  );

  // apb decode
  assign prep     = psel_i & penable_i & ~st_ff.pready;
  assign done     = psel_i & penable_i & st_ff.pready;
  assign hit_csr  = (paddr_i == stt_pkg::ADDR_CSR);
  assign hit_rvr  = (paddr_i == stt_pkg::ADDR_RVR);
  assign hit_cvr  = (paddr_i == stt_pkg::ADDR_CVR);
  assign hit_cal  = (paddr_i == stt_pkg::ADDR_CAL);
  assign hit_ist  = (paddr_i == stt_pkg::ADDR_IST);
  assign hit_imsk = (paddr_i == stt_pkg::ADDR_IMSK);
  assign bad      = (paddr_i[1:0] != stt_pkg::ALIGN_OK) | ~(hit_csr | hit_rvr | hit_cvr | hit_cal | hit_ist | hit_imsk); // R4
  assign wr_ok    = done & pwrite_i & ~bad;
  assign wr_csr   = wr_ok & hit_csr;
  assign wr_rvr   = wr_ok & hit_rvr;
  assign wr_cvr   = wr_ok & hit_cvr;
  assign wr_imsk  = wr_ok & hit_imsk;
  // read side effects act in the cycle the read data is captured
  assign rd_csr   = prep & ~pwrite_i & hit_csr;
  assign rd_ist   = prep & ~pwrite_i & hit_ist;

  // counting clock: processor clock or synchronised reference edge
  assign src_eff  = NO_REF | st_ff.clksrc; // R14
  assign ref_rise = ref_s & ~st_ff.ref_prev;

  assign cif.tick       = st_ff.en & ~halt_s & (src_eff | ref_rise); // R2 R3 R8
  assign cif.load       = wr_csr & pwdata_i[stt_pkg::CSR_EN_BIT] & ~st_ff.en; // R10
  assign cif.clear      = wr_cvr; // R13
  assign cif.reload_val = st_ff.reload;

  // register read values
  always_comb begin
    csr_val                        = stt_pkg::RDATA_ZERO;
    csr_val[stt_pkg::CSR_EN_BIT]   = st_ff.en;
    csr_val[stt_pkg::CSR_INT_BIT]  = st_ff.tick_exception_enable;
    csr_val[stt_pkg::CSR_SRC_BIT]  = src_eff; // R14
    csr_val[stt_pkg::CSR_FLAG_BIT] = st_ff.flag; // R7
    cal_val                        = stt_pkg::RDATA_ZERO;
    cal_val[stt_pkg::CNT_W-1:0]    = TEN_MILLISECOND_RELOAD; // R15
    cal_val[stt_pkg::CAL_NO_REFERENCE_CLOCK_BIT] = NO_REF;
    cal_val[stt_pkg::CAL_SKEW_BIT] = SKEW;
    rd_mux                         = stt_pkg::RDATA_ZERO;
    if (hit_csr) begin
      rd_mux = csr_val;
    end else if (hit_rvr) begin
      rd_mux[stt_pkg::CNT_W-1:0] = st_ff.reload;
    end else if (hit_cvr) begin
      rd_mux[stt_pkg::CNT_W-1:0] = cif.cur; // R13
    end else if (hit_cal) begin
      rd_mux = cal_val; // R6
    end else if (hit_ist) begin
      rd_mux[stt_pkg::IST_ZERO_BIT] = st_ff.ist;
    end else if (hit_imsk) begin
      rd_mux[stt_pkg::IST_ZERO_BIT] = st_ff.imsk;
    end
  end

  // next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.ref_prev = ref_s;
    nxt_st.pready   = prep;
    nxt_st.pslverr  = prep & bad; // R4
    if (prep) begin
      nxt_st.prdata = (pwrite_i | bad) ? stt_pkg::RDATA_ZERO : rd_mux;
    end
    if (wr_csr) begin
      nxt_st.en      = pwdata_i[stt_pkg::CSR_EN_BIT]; // R10
      nxt_st.tick_exception_enable = pwdata_i[stt_pkg::CSR_INT_BIT]; // R9
      if (!NO_REF) begin
        nxt_st.clksrc = pwdata_i[stt_pkg::CSR_SRC_BIT]; // R8 R14
      end
    end
    if (wr_rvr) begin
      nxt_st.reload = pwdata_i[stt_pkg::CNT_W-1:0]; // R11
    end
    if (wr_imsk) begin
      nxt_st.imsk = pwdata_i[stt_pkg::IST_ZERO_BIT];
    end
    // a new zero crossing wins over a clear in the same cycle
    nxt_st.flag = (st_ff.flag & ~rd_csr & ~wr_cvr) | cif.zero_evt; // R7 R13 R16
    nxt_st.ist  = (st_ff.ist & ~rd_ist) | cif.zero_evt;
    nxt_st.exc  = cif.zero_evt & st_ff.tick_exception_enable; // R9
    nxt_st.irq  = nxt_st.ist & nxt_st.imsk;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff         <= '0;
      st_ff.en      <= stt_pkg::CSR_RST[stt_pkg::CSR_EN_BIT]; // R6
      st_ff.tick_exception_enable <= stt_pkg::CSR_RST[stt_pkg::CSR_INT_BIT];
      st_ff.clksrc  <= stt_pkg::CSR_RST[stt_pkg::CSR_SRC_BIT];
      st_ff.flag    <= stt_pkg::CSR_RST[stt_pkg::CSR_FLAG_BIT];
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o   = st_ff.prdata;
  assign pready_o   = st_ff.pready;
  assign pslverr_o  = st_ff.pslverr;
  assign tick_exc_o = st_ff.exc;
  assign irq_o      = st_ff.irq;

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_count_decrement: assert property ( // R1
    (cif.tick && !cif.load && !cif.clear && cif.cur != stt_pkg::CNT_ZERO)
    |=> (cif.cur == $past(cif.cur) - stt_pkg::CNT_ONE))
    else $error("counter did not decrement by one");

  a_count_reload_zero: assert property ( // R1
    (cif.tick && !cif.load && !cif.clear && cif.cur == stt_pkg::CNT_ZERO)
    |=> (cif.cur == $past(cif.reload_val)))
    else $error("counter did not reload after zero");

  a_halt_freezes_count: assert property ( // R2
    (halt_s && !cif.load && !cif.clear) |=> $stable(cif.cur))
    else $error("counter moved while halted");

  a_tick_needs_enable: assert property ( // R3
    cif.tick |-> (st_ff.en && !halt_s))
    else $error("count tick without enable");

  a_ref_source_edge: assert property ( // R8
    (cif.tick && !src_eff) |-> (ref_s && !st_ff.ref_prev))
    else $error("reference source counted without a reference edge");

  a_zero_sets_flag: assert property ( // R7
    cif.zero_evt |=> st_ff.flag)
    else $error("count flag not set on zero");

  a_exc_follows_zero: assert property ( // R9
    st_ff.exc |-> ($past(cif.zero_evt) && $past(st_ff.tick_exception_enable)))
    else $error("exception request without enabled zero crossing");

  a_exc_when_enabled: assert property ( // R9
    (cif.zero_evt && st_ff.tick_exception_enable) |=> st_ff.exc ##1 !st_ff.exc)
    else $error("exception request missing or not one cycle");

  a_enable_loads: assert property ( // R10
    cif.load |=> (cif.cur == $past(cif.reload_val)) && st_ff.en)
    else $error("enable did not load reload value");

  a_reload_zero_quiet: assert property ( // R11
    (cif.cur == stt_pkg::CNT_ZERO && cif.reload_val == stt_pkg::CNT_ZERO && !cif.load)
    |=> !cif.zero_evt && cif.cur == stt_pkg::CNT_ZERO)
    else $error("zero reload produced an event");

  a_cvr_write_clears: assert property ( // R13
    (wr_cvr && !cif.zero_evt) |=> (cif.cur == stt_pkg::CNT_ZERO) && !st_ff.flag)
    else $error("current value write did not clear");

  a_csr_read_clears: assert property ( // R16
    (rd_csr && !cif.zero_evt) |=> !st_ff.flag ##1 (st_ff.prdata[stt_pkg::CSR_FLAG_BIT] == $past(st_ff.flag, 2)))
    else $error("status read did not return and clear the flag");

  a_no_reference_clock_src_one: assert property ( // R14
    (prep && !pwrite_i && hit_csr && NO_REF) |=> st_ff.prdata[stt_pkg::CSR_SRC_BIT])
    else $error("clock source not reading one without reference");

  a_cal_read_value: assert property ( // R15
    (prep && !pwrite_i && hit_cal) |=> st_ff.prdata[stt_pkg::CNT_W-1:0] == TEN_MILLISECOND_RELOAD)
    else $error("calibration field wrong");

  a_apb_one_wait: assert property (
    (psel_i && penable_i && !st_ff.pready) |=> st_ff.pready ##1 !st_ff.pready)
    else $error("apb answer not one cycle");

  // counter, register, flag, exception and interrupt checks
  a_zero_from_one: assert property ( // R11
    cif.zero_evt |-> (cif.cur == stt_pkg::CNT_ZERO) && ($past(cif.cur) == stt_pkg::CNT_ONE))
    else $error("zero event without a one to zero step");

  a_disabled_holds: assert property ( // R10
    (!st_ff.en && !cif.load && !cif.clear) |=> $stable(cif.cur))
    else $error("counter moved while disabled");

  a_no_exc_disabled: assert property ( // R9
    (cif.zero_evt && !st_ff.tick_exception_enable) |=> !st_ff.exc)
    else $error("exception request while exception enable is off");

  a_flag_sticky: assert property ( // R7
    (st_ff.flag && !rd_csr && !wr_cvr) |=> st_ff.flag)
    else $error("count flag lost without a read or clear");

  a_flag_from_zero: assert property ( // R7
    $rose(st_ff.flag) |-> $past(cif.zero_evt))
    else $error("count flag set without a zero crossing");

  a_ist_sticky: assert property (
    (st_ff.ist && !rd_ist) |=> st_ff.ist)
    else $error("interrupt status lost without a read");

  a_ist_read_clears: assert property (
    (rd_ist && !cif.zero_evt) |=> !st_ff.ist)
    else $error("interrupt status not cleared by read");

  a_irq_on_zero: assert property (
    (cif.zero_evt && st_ff.imsk && !wr_imsk) |=> st_ff.irq)
    else $error("unmasked zero crossing did not raise the interrupt");

  a_irq_masked: assert property (
    !st_ff.imsk |-> !st_ff.irq)
    else $error("interrupt raised while masked");

  a_reload_write: assert property ( // R11
    wr_rvr |=> st_ff.reload == $past(pwdata_i[stt_pkg::CNT_W-1:0]))
    else $error("reload write not stored");

  a_bad_write_ignored: assert property (
    (done && pwrite_i && bad) |=> $stable(st_ff.reload) && $stable(st_ff.en) && $stable(st_ff.imsk))
    else $error("refused write changed a register");

  a_misaligned_error: assert property (
    (prep && paddr_i[1:0] != stt_pkg::ALIGN_OK) |=> st_ff.pslverr)
    else $error("misaligned access not refused");

  a_write_reads_zero: assert property (
    (prep && pwrite_i) |=> st_ff.prdata == stt_pkg::RDATA_ZERO)
    else $error("read data not zero for a write");

  a_rdata_holds: assert property (
    !prep |=> $stable(st_ff.prdata))
    else $error("read data changed outside an access");

  a_cal_flags_read: assert property ( // R6
    (prep && !pwrite_i && hit_cal)
    |=> (st_ff.prdata[stt_pkg::CAL_NO_REFERENCE_CLOCK_BIT] == NO_REF) && (st_ff.prdata[stt_pkg::CAL_SKEW_BIT] == SKEW))
    else $error("calibration flags wrong");

  a_cvr_read_live: assert property ( // R13
    (prep && !pwrite_i && hit_cvr) |=> st_ff.prdata[stt_pkg::CNT_W-1:0] == $past(cif.cur))
    else $error("current value read not live");

  a_csr_read_enable: assert property ( // R10
    (prep && !pwrite_i && hit_csr) |=> st_ff.prdata[stt_pkg::CSR_EN_BIT] == $past(st_ff.en))
    else $error("enable bit read wrong");

  c_zero_with_exc: cover property (cif.zero_evt && st_ff.tick_exception_enable);
  c_halt_while_on: cover property (st_ff.en && halt_s ##1 !halt_s);
  c_flag_read_set: cover property (rd_csr && st_ff.flag);
  c_ref_count: cover property (cif.tick && !src_eff);
  c_cvr_clear_run: cover property (wr_cvr && st_ff.en);
endmodule // stt_timer

// ---- tb_system_tick_down_counter.sv ----
// testbench: apb register, counting, flag, interrupt, halt and reference clock checks for the tick timer
`timescale 1ns/1ps
module tb_system_tick_down_counter;
  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } stt_row_type;
  logic        sys_clk_i = 1'h0;
  logic        rstn_i    = 1'h0;
  logic        psel      = 1'h0;
  logic        penable   = 1'h0;
  logic        pwrite    = 1'h0;
  logic [31:0] paddr     = 32'h0000_0000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic        ref_clk   = 1'h0;
  logic        ref_run   = 1'h0;
  logic [1:0]  ref_div   = 2'h0;
  logic        dbg_halt  = 1'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        tick_exc_o;
  logic        irq_o;
  logic [31:0] prdata_nr;
  logic [31:0] rd;
  logic [31:0] hold_val;
  logic        er;
  int          fail_count = 0;
  int          num_checks = 0;
  int          pulse_cnt  = 0;
  int          c0;
  int          n;
  stt_row_type rows [12] = '{
    '{1'h1, stt_pkg::ADDR_RVR, 32'h0000_0005, 32'h0000_0000, 1'h0},
    '{1'h0, stt_pkg::ADDR_RVR, 32'h0000_0000, 32'h0000_0005, 1'h0},
    '{1'h1, stt_pkg::ADDR_RVR, 32'hffff_ffff, 32'h0000_0000, 1'h0},
    '{1'h0, stt_pkg::ADDR_RVR, 32'h0000_0000, 32'h00ff_ffff, 1'h0},
    '{1'h1, stt_pkg::ADDR_CAL, 32'hffff_ffff, 32'h0000_0000, 1'h0},
    '{1'h0, stt_pkg::ADDR_CAL, 32'h0000_0000, {8'h00, stt_pkg::CAL_TEN_MILLISECOND_RELOAD_RST}, 1'h0},
    '{1'h1, stt_pkg::ADDR_CSR, 32'h0000_0004, 32'h0000_0000, 1'h0},
    '{1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000, 32'h0000_0004, 1'h0},
    '{1'h0, 32'he000_e028,     32'h0000_0000, 32'h0000_0000, 1'h1},
    '{1'h1, 32'he000_e011,     32'h0000_0001, 32'h0000_0000, 1'h1},
    '{1'h1, stt_pkg::ADDR_IMSK, 32'h0000_0001, 32'h0000_0000, 1'h0},
    '{1'h0, stt_pkg::ADDR_IMSK, 32'h0000_0000, 32'h0000_0001, 1'h0}
  };

  always #10 sys_clk_i = ~sys_clk_i;

  // reference clock of eight system cycles, still while not running
  always @(posedge sys_clk_i) begin
    if (ref_run) begin
      ref_div <= ref_div + 2'h1;
      if (ref_div == 2'h3) ref_clk <= ~ref_clk;
    end
    if (tick_exc_o === 1'h1) pulse_cnt <= pulse_cnt + 1;
  end

  stt_timer i_dut (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .psel_i     (psel),
    .penable_i  (penable),
    .pwrite_i   (pwrite),
    .paddr_i    (paddr),
    .pwdata_i   (pwdata),
    .prdata_o   (prdata_o),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o),
    .ref_clk_i  (ref_clk),
    .dbg_halt_i (dbg_halt),
    .tick_exc_o (tick_exc_o),
    .irq_o      (irq_o)
  );

  // second instance built without a reference clock
  stt_timer #(
    .NO_REF (1'h1)
  ) i_dut_no_reference_clock (
    .sys_clk_i  (sys_clk_i),
    .rstn_i     (rstn_i),
    .psel_i     (psel),
    .penable_i  (penable),
    .pwrite_i   (pwrite),
    .paddr_i    (paddr),
    .pwdata_i   (pwdata),
    .prdata_o   (prdata_nr),
    .pready_o   (),
    .pslverr_o  (),
    .ref_clk_i  (ref_clk),
    .dbg_halt_i (dbg_halt),
    .tick_exc_o (),
    .irq_o      ()
  );

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk_i);
      if (pready_o === 1'h1) break;
    end
    if (i == 16) begin
      fail_count++;
      results();
    end else begin
      rd = prdata_o;
      er = pslverr_o;
      psel    <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // cycles until the next exception pulse
  task automatic wait_pulse(input int lim);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (tick_exc_o !== 1'h1 && n < lim);
    if (n >= lim) begin
      fail_count++;
      results();
    end
  endtask

  task automatic start(input logic [31:0] rv, input logic [31:0] csr);
    apb(1'h1, stt_pkg::ADDR_RVR, rv);
    apb(1'h1, stt_pkg::ADDR_CVR, 32'h0000_0000);
    apb(1'h1, stt_pkg::ADDR_CSR, csr);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, stt_pkg::CSR_RST);
    chk(prdata_nr, 32'h0000_0004);
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].addr, rows[k].wdata);
      chk(rd, rows[k].rdata);
      chk({31'h0, er}, {31'h0, rows[k].err});
    end
    // period of reload plus one processor clocks
    start(32'h0000_0027, 32'h0000_0007);
    wait_pulse(100);
    wait_pulse(100);
    chk(32'(n), 32'h0000_0028);
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, 32'h0001_0007);
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    chk({31'h0, irq_o}, 32'h0000_0001);
    apb(1'h0, stt_pkg::ADDR_IST, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'h0, stt_pkg::ADDR_IST, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0000);
    apb(1'h0, stt_pkg::ADDR_CVR, 32'h0000_0000);
    chk({31'h0, rd < 32'h0000_0028}, 32'h0000_0001);
    wait_pulse(100);
    apb(1'h1, stt_pkg::ADDR_CVR, 32'h0000_1234);
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    // masked interrupt keeps status but not the line
    apb(1'h1, stt_pkg::ADDR_IMSK, 32'h0000_0000);
    wait_pulse(100);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    apb(1'h0, stt_pkg::ADDR_IST, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    // debug halt freezes the count
    dbg_halt <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    apb(1'h0, stt_pkg::ADDR_CVR, 32'h0000_0000);
    hold_val = rd;
    repeat (10) @(posedge sys_clk_i);
    apb(1'h0, stt_pkg::ADDR_CVR, 32'h0000_0000);
    chk(rd, hold_val);
    dbg_halt <= 1'h0;
    // exception request disabled
    apb(1'h1, stt_pkg::ADDR_CSR, 32'h0000_0005);
    repeat (2) @(posedge sys_clk_i);
    c0 = pulse_cnt;
    repeat (100) @(posedge sys_clk_i);
    chk(32'(pulse_cnt - c0), 32'h0000_0000);
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, 32'h0001_0005);
    // reference clock source
    ref_run <= 1'h1;
    apb(1'h1, stt_pkg::ADDR_CSR, 32'h0000_0003);
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(prdata_nr & 32'h0000_0004, 32'h0000_0004);
    wait_pulse(400);
    wait_pulse(400);
    chk(32'(n), 32'h0000_0140);
    ref_run <= 1'h0;
    // reload of zero never fires
    start(32'h0000_0000, 32'h0000_0007);
    c0 = pulse_cnt;
    repeat (100) @(posedge sys_clk_i);
    chk(32'(pulse_cnt - c0), 32'h0000_0000);
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    // disable stops the counter
    start(32'h0000_0014, 32'h0000_0005);
    apb(1'h1, stt_pkg::ADDR_CSR, 32'h0000_0000);
    apb(1'h0, stt_pkg::ADDR_CVR, 32'h0000_0000);
    hold_val = rd;
    repeat (5) @(posedge sys_clk_i);
    apb(1'h0, stt_pkg::ADDR_CVR, 32'h0000_0000);
    chk(rd, hold_val);
    // reset in mid-run
    start(32'h0000_001e, 32'h0000_0007);
    @(posedge sys_clk_i);
    rstn_i <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    apb(1'h0, stt_pkg::ADDR_CSR, 32'h0000_0000);
    chk(rd, stt_pkg::CSR_RST);
    apb(1'h0, stt_pkg::ADDR_IMSK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    results();
  end
endmodule // tb_system_tick_down_counter
